// ---- ucnt_driver.sv ----
// Driving logic for the counter: an APB slave whose registers set the
// load, enable, direction and preset pins and make the count clock.
// Assumes the counter samples every pin through its own synchronisers.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ucnt_driver
  import ucnt_pkg::*;
(
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the counter.
  ucnt_if.driver link
);

  ////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_ctrl = (paddr == CTRL_OFFSET);
  wire hit_half = (paddr == HALF_PERIOD_OFFSET);
  wire hit_pulses = (paddr == PULSES_OFFSET);
  wire hit_status = (paddr == STATUS_OFFSET);
  wire hit_any = hit_ctrl | hit_half | hit_pulses | hit_status;
  wire wr_access = access_phase & pwrite;

  // Pin-polarity control flops; the pins come straight from them so the
  // enable and direction may change at any pclk edge.
  logic load_n;
  logic enable_n;
  logic down;
  logic run;
  logic [COUNT_WIDTH-1:0] preset;
  logic [HALF_PERIOD_WIDTH-1:0] half_period;
  logic [PULSES_WIDTH-1:0] pulses_left;

  ////////////////////////////////////////////////////////////////////////
  // Status input synchronisers.

  localparam int SIN_WIDTH = COUNT_WIDTH + 2;
  // Reset to the counter's idle levels, ripple high, so STATUS never shows
  // a false ripple pulse in the first reads after reset.
  localparam logic [SIN_WIDTH-1:0] SIN_IDLE = {1'b1, 1'b0, COUNT_RESET};
  logic [SIN_WIDTH-1:0] sin_first;
  logic [SIN_WIDTH-1:0] sin;

  // The flag is only sampled as data, never used as a clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_first <= SIN_IDLE;
      sin <= SIN_IDLE;
    end else begin
      sin_first <= {link.ripple_clock_out, link.terminal_flag, link.count_outputs}; // R8
      sin <= sin_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count clock generator.

  ucnt_clkgen_t state;
  ucnt_clkgen_t next_state;
  logic [HALF_PERIOD_WIDTH-1:0] timer;
  wire timer_done = (timer == half_period);
  wire more = run | (pulses_left != '0);

  always_comb begin
    case (state)
      CG_IDLE: next_state = more ? CG_HIGH : CG_IDLE;
      CG_HIGH: next_state = timer_done ? CG_LOW : CG_HIGH;
      // Low half keeps the full programmed length so carries can settle.
      CG_LOW: begin
        if (!timer_done) begin
          next_state = CG_LOW; // R14
        end else begin
          next_state = more ? CG_HIGH : CG_IDLE;
        end
      end
      default: next_state = CG_IDLE;
    endcase
  end

  wire pulse_done = (state == CG_HIGH) & timer_done & ~run & (pulses_left != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CG_IDLE;
      timer <= '0;
      link.count_clock <= 1'b0;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? '0 : timer + HALF_PERIOD_WIDTH'(1);
      link.count_clock <= (next_state == CG_HIGH); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and read data.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_n <= 1'b1;
      enable_n <= 1'b1;
      down <= 1'b0;
      run <= 1'b0;
      preset <= COUNT_RESET;
      half_period <= HALF_PERIOD_RESET;
      pulses_left <= PULSES_RESET;
    end else begin
      if (wr_access && hit_ctrl) begin
        load_n <= ~pwdata[CTRL_LOAD_BIT];
        enable_n <= ~pwdata[CTRL_ENABLE_BIT]; // R12 R15
        down <= pwdata[CTRL_DOWN_BIT]; // R12
        run <= pwdata[CTRL_RUN_BIT];
        preset <= pwdata[CTRL_PRESET_LSB +: COUNT_WIDTH];
      end
      if (wr_access && hit_half) begin
        half_period <= pwdata[HALF_PERIOD_WIDTH-1:0];
      end
      if (wr_access && hit_pulses) begin
        pulses_left <= pwdata[PULSES_WIDTH-1:0];
      end else if (pulse_done) begin
        pulses_left <= pulses_left - PULSES_WIDTH'(1);
      end
    end
  end

  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      read_mux[CTRL_LOAD_BIT] = ~load_n;
      read_mux[CTRL_ENABLE_BIT] = ~enable_n;
      read_mux[CTRL_DOWN_BIT] = down;
      read_mux[CTRL_RUN_BIT] = run;
      read_mux[CTRL_PRESET_LSB +: COUNT_WIDTH] = preset;
    end else if (hit_half) begin
      read_mux[HALF_PERIOD_WIDTH-1:0] = half_period;
    end else if (hit_pulses) begin
      read_mux[PULSES_WIDTH-1:0] = pulses_left;
    end else if (hit_status) begin
      read_mux[STAT_COUNT_LSB +: COUNT_WIDTH] = sin[COUNT_WIDTH-1:0];
      read_mux[STAT_TERMINAL_BIT] = sin[COUNT_WIDTH];
      read_mux[STAT_RIPPLE_BIT] = sin[COUNT_WIDTH+1];
      read_mux[STAT_BUSY_BIT] = (state != CG_IDLE);
    end
  end

  // Read data is captured in the setup cycle so it stands in the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= read_mux;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  assign link.async_load_n = load_n;
  assign link.count_enable_n = enable_n;
  assign link.count_down = down;
  assign link.preset_inputs = preset;

endmodule
`default_nettype wire

// ---- ucnt_pkg.sv ----
// Shared constants for the reversible modulo-16 counter and its driver.
// Assumes both ends and the link interface import this package whole.
package ucnt_pkg;

  // Counter geometry and terminal values.
  localparam int COUNT_WIDTH = 4;
  localparam logic [3:0] COUNT_TOP = 4'hF;
  localparam logic [3:0] COUNT_BOTTOM = 4'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // Driver register offsets (byte addresses, one aligned word each).
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] HALF_PERIOD_OFFSET = 8'h04;
  localparam logic [7:0] PULSES_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;

  // Control register fields.
  localparam int CTRL_LOAD_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_DOWN_BIT = 2;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_PRESET_LSB = 4;

  // Status register fields.
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_TERMINAL_BIT = 4;
  localparam int STAT_RIPPLE_BIT = 5;
  localparam int STAT_BUSY_BIT = 6;

  // Clock generator: half period is the register value plus one cycle.
  localparam int HALF_PERIOD_WIDTH = 16;
  localparam logic [15:0] HALF_PERIOD_RESET = 16'h0003;
  localparam int PULSES_WIDTH = 16;
  localparam logic [15:0] PULSES_RESET = 16'h0000;

  // States of the driver's count clock generator.
  typedef enum logic [2:0] {
    CG_IDLE = 3'b001,
    CG_HIGH = 3'b010,
    CG_LOW = 3'b100
  } ucnt_clkgen_t;

endpackage

// ---- ucnt_if.sv ----
// Pin-level link between the counter device and its driving logic.
// Assumes nothing: plain wires, no clocking, one modport per end.
`timescale 1ns/1ps
`default_nettype none
interface ucnt_if;
  import ucnt_pkg::*;
  logic count_clock;
  logic async_load_n;
  logic count_enable_n;
  logic count_down;
  logic [COUNT_WIDTH-1:0] preset_inputs;
  logic [COUNT_WIDTH-1:0] count_outputs;
  logic terminal_flag;
  logic ripple_clock_out;

  modport device (
    input count_clock,
    input async_load_n,
    input count_enable_n,
    input count_down,
    input preset_inputs,
    output count_outputs,
    output terminal_flag,
    output ripple_clock_out
  );

  modport driver (
    output count_clock,
    output async_load_n,
    output count_enable_n,
    output count_down,
    output preset_inputs,
    input count_outputs,
    input terminal_flag,
    input ripple_clock_out
  );
endinterface
`default_nettype wire

// ---- ucnt_device.sv ----
// Reversible modulo-16 counter with asynchronous-style preset, terminal
// flag and ripple clock, rebuilt on the system clock pclk.
// Assumes every link input may change at any time: each passes two
// flip-flops before use, so the count clock must hold each level for at
// least one pclk period and all link effects lag the pins by the sync.
// The preset bits are synchronised one by one, so the driver must hold
// them steady for the whole time the load is asserted.
//
// Summary of operation
// [R1] Four-bit count wraps modulo sixteen both ways.
// [R2] Load low copies preset inputs into count.
// [R3] Load overrides counting, holding and clock.
// [R4] Count only on rising clock with enable low.
// [R5] Direction low increments, high decrements.
// [R6] Flag high at fifteen up, zero down.
// [R7] Flag follows count and direction changes only.
// [R8] Flag must never serve as a clock.
// [R9] Ripple low from falling to next rising edge.
// [R10] Ripple forced high on inhibit, no flag, load.
// [R11] Flag ignores the count enable input.
// [R12] Enable and direction may change anytime, respecting setup.
// [R13] Ripple cascade clocks upper stages from ripple.
// [R14] Parallel cascade needs clock low for carry.
// [R15] Look-ahead enables combine lower flags plus inhibit.
// [R16] Released load keeps preset until counting edge.
`timescale 1ns/1ps
`default_nettype none
module ucnt_device
  import ucnt_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
) (
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link to the driving logic.
  ucnt_if.device link,
  // Local observation of the counter.
  output logic [WIDTH-1:0] count_value,
  output logic terminal_now
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // Packed order: clock, load, enable, direction, preset bits.
  localparam int SYNC_WIDTH = WIDTH + 4;
  localparam int CLK_POS = WIDTH + 3;
  localparam int LOAD_POS = WIDTH + 2;
  localparam int ENABLE_POS = WIDTH + 1;
  localparam int DOWN_POS = WIDTH;
  // Idle levels: clock low, load and enable released, counting up.
  // Resetting to them keeps the first edges after reset from loading or counting.
  localparam logic [SYNC_WIDTH-1:0] SYNC_IDLE = {1'b0, 1'b1, 1'b1, 1'b0, {WIDTH{1'b0}}};

  logic [SYNC_WIDTH-1:0] raw_in;
  logic [SYNC_WIDTH-1:0] sync_first;
  logic [SYNC_WIDTH-1:0] sync_in;

  assign raw_in = {link.count_clock, link.async_load_n, link.count_enable_n,
                   link.count_down, link.preset_inputs};

  // The first stage feeds only the second; all logic reads sync_in.
  // Each pin is sampled as a level, so a pulse shorter than one pclk period
  // may be lost; the driver keeps every level for at least one period.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_first[gi] <= SYNC_IDLE[gi];
          sync_in[gi] <= SYNC_IDLE[gi];
        end else begin
          sync_first[gi] <= raw_in[gi];
          sync_in[gi] <= sync_first[gi];
        end
      end
    end
  endgenerate

  // Active-high views of the synchronised pins, named for what they do.
  wire clk_level = sync_in[CLK_POS];
  wire load_active = ~sync_in[LOAD_POS];
  wire enable_active = ~sync_in[ENABLE_POS];
  wire dir_down = sync_in[DOWN_POS];
  wire [WIDTH-1:0] preset_value = sync_in[WIDTH-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Count clock edge detection.

  // The previous level resets to the idle low level of the count clock, so
  // leaving reset never shows a false rising or falling edge.
  logic clk_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_level;
    end
  end

  wire clk_rise = clk_level & ~clk_prev;
  wire clk_fall = ~clk_level & clk_prev;
  // A fall and a rise never occur together: each needs a level change of
  // the synchronised clock, and only one change is seen per pclk edge.

  ////////////////////////////////////////////////////////////////////////
  // Counter core.

  // Terminal decode depends only on count and direction, never on the
  // count enable, so look-ahead cascades can chain flags across stages.
  function automatic logic at_terminal(input logic [WIDTH-1:0] value,
                                       input logic down);
    logic [WIDTH-1:0] top;
    top = {WIDTH{1'b1}};
    at_terminal = down ? (value == '0) : (value == top); // R6 R11
  endfunction

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic terminal;
  logic next_terminal;
  logic ripple;
  logic next_ripple;

  // Wrap-around in both directions falls out of the fixed-width arithmetic.
  wire count_step = clk_rise & enable_active; // R4
  wire [WIDTH-1:0] count_inc = count + WIDTH'(1); // R1
  wire [WIDTH-1:0] count_dec = count - WIDTH'(1); // R1

  // Load is checked first so it wins over any clock or enable activity;
  // once released, nothing moves until a qualifying rising edge.
  // The load acts three pclk edges after its pin falls, not at once: that is
  // the cost of sampling every pin on the system clock.
  always_comb begin
    if (load_active) begin
      next_count = preset_value; // R2 R3
    end else if (count_step) begin
      next_count = dir_down ? count_dec : count_inc; // R5
    end else begin
      next_count = count; // R4 R16
    end
  end

  // Registered from the next count and current direction, so the flag
  // changes only with a state change or a direction change and is free of
  // decoding spikes.
  assign next_terminal = at_terminal(next_count, dir_down); // R7 R8

  // Ripple output: low for the low half of a clock while enabled at a
  // terminal state, high otherwise.
  // A pulse lasts exactly the low half of the count clock, so a stage
  // clocked from it sees its rising edge when this stage's clock rises.
  wire ripple_forced_high = load_active | ~enable_active | ~terminal; // R10

  always_comb begin
    if (ripple_forced_high) begin
      next_ripple = 1'b1; // R10
    end else if (clk_fall) begin
      next_ripple = 1'b0; // R9
    end else if (clk_rise) begin
      next_ripple = 1'b1; // R9
    end else begin
      next_ripple = ripple;
    end
  end

  // Each register has its own short process so that its reset value sits
  // next to its update.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET[WIDTH-1:0];
    end else begin
      count <= next_count;
    end
  end

  // The count resets to zero while counting up, so the flag starts low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal <= 1'b0;
    end else begin
      terminal <= next_terminal;
    end
  end

  // Idle high, as when the count enable is released.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ripple <= 1'b1;
    end else begin
      ripple <= next_ripple;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Every output comes straight from a register, so the pins never show
  // decoding spikes while the count settles.
  assign link.count_outputs = count;
  assign link.terminal_flag = terminal;
  assign link.ripple_clock_out = ripple; // R13 R14
  assign count_value = count;
  assign terminal_now = terminal;

endmodule
`default_nettype wire

// ---- ucnt_monitor.sv ----
// Concurrent checks on the counter link, watching the interface wires.
// Assumes each pin reaches the counter through two pclk flops and a register.
`timescale 1ns/1ps
`default_nettype none
module ucnt_monitor
  import ucnt_pkg::*;
(
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link wires.
  input wire logic count_clock,
  input wire logic async_load_n,
  input wire logic count_enable_n,
  input wire logic count_down,
  input wire logic [COUNT_WIDTH-1:0] preset_inputs,
  input wire logic [COUNT_WIDTH-1:0] count_outputs,
  input wire logic terminal_flag,
  input wire logic ripple_clock_out
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Windows of three to six samples cover the synchroniser latency.
  AST_LOAD_COPY:
    assert property ((!async_load_n && $stable(preset_inputs)) [*4]
      |-> count_outputs == preset_inputs) else $error("count differs from held preset");
  AST_HOLD:
    assert property ((async_load_n && count_enable_n) [*4] |-> $stable(count_outputs))
    else $error("count moved while inhibited");
  AST_NO_EDGE:
    assert property ((async_load_n && !count_clock) [*5] |-> $stable(count_outputs))
    else $error("count moved without a clock edge");
  AST_STEP:
    assert property ((async_load_n && $stable(count_down)) [*6] ##0 $changed(count_outputs)
      |-> count_outputs == (count_down ? $past(count_outputs) - 4'h1
      : $past(count_outputs) + 4'h1)) else $error("count step wrong");
  AST_TERMINAL:
    assert property ($stable(count_down) [*5] |-> terminal_flag == (count_down ?
      count_outputs == COUNT_BOTTOM : count_outputs == COUNT_TOP))
    else $error("terminal flag does not match count and direction");
  AST_RC_INHIBIT:
    assert property (count_enable_n [*4] |-> ripple_clock_out)
    else $error("ripple low while inhibited");
  AST_RC_LOAD:
    assert property ((!async_load_n) [*4] |-> ripple_clock_out)
    else $error("ripple low during load");
  AST_RC_NO_TERM:
    assert property ((!terminal_flag) [*3] |-> ripple_clock_out)
    else $error("ripple low without terminal count");
  AST_RC_LOW:
    assert property ((!count_enable_n && async_load_n && $stable(count_down)) [*4]
      ##0 ($fell(count_clock) && terminal_flag) ##1
      (!count_clock && !count_enable_n && async_load_n && $stable(count_down)) [*3]
      |-> !ripple_clock_out) else $error("ripple not low after falling clock");
  AST_RC_END:
    assert property ($rose(count_clock) |-> ##[1:5] ripple_clock_out)
    else $error("ripple not back high after rising clock");
  ////////////////////////////////////////////////////////////////////////////
  COV_RIPPLE: cover property ($fell(ripple_clock_out));
  COV_WRAP_UP: cover property (count_outputs == 4'hF ##[1:60] count_outputs == 4'h0);
  COV_LOAD: cover property ((!async_load_n) [*4]);
endmodule
`default_nettype wire

// ---- ucnt_tb_top.sv ----
// Bench for the driver and counter joined by the link interface.
// Assumes software access over APB only; the counter is seen through STATUS and, in one check, its local outputs.
`timescale 1ns/1ps
`default_nettype none
module ucnt_tb_top;
  import ucnt_pkg::*;
  logic pclk;
  logic presetn;
  logic [ADDR_WIDTH-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] count_value;
  logic terminal_now;
  logic [31:0] rdata;
  logic rerr;
  int err_total;
  int total_checks;
  ucnt_if link ();
  ucnt_driver i_ucnt_driver (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  ucnt_device #(.WIDTH(COUNT_WIDTH)) i_ucnt_device (.pclk(pclk), .presetn(presetn),
    .link(link), .count_value(count_value), .terminal_now(terminal_now));
  ucnt_monitor i_ucnt_monitor (.pclk(pclk), .presetn(presetn),
    .count_clock(link.count_clock), .async_load_n(link.async_load_n),
    .count_enable_n(link.count_enable_n), .count_down(link.count_down),
    .preset_inputs(link.preset_inputs), .count_outputs(link.count_outputs),
    .terminal_flag(link.terminal_flag), .ripple_clock_out(link.ripple_clock_out));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] st(input logic [3:0] c, input logic t, input logic r);
    st = 32'h0;
    st[STAT_COUNT_LSB +: 4] = c;
    st[STAT_TERMINAL_BIT] = t;
    st[STAT_RIPPLE_BIT] = r;
  endfunction
  function automatic logic [31:0] ctrl(input logic ld, input logic en, input logic dn,
                                       input logic [3:0] p);
    ctrl = 32'h0;
    ctrl[CTRL_LOAD_BIT] = ld;
    ctrl[CTRL_ENABLE_BIT] = en;
    ctrl[CTRL_DOWN_BIT] = dn;
    ctrl[CTRL_PRESET_LSB +: 4] = p;
  endfunction
  localparam logic [31:0] MSK_ALL = 32'h0000003F;
  localparam logic [31:0] MSK_CF = 32'h0000001F;
  localparam logic [31:0] MSK_BUSY = 32'h00000001 << STAT_BUSY_BIT;
  localparam logic [31:0] MSK_RUN = 32'h00000001 << CTRL_RUN_BIT;
  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; one idle edge at the end keeps
  // back-to-back calls from assigning psel twice in one time step.
  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      check(32'h0, 32'h1);
      finish_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] exp);
    int n;
    n = 0;
    apb_xfer(1'b0, STATUS_OFFSET, 32'h0);
    while ((rdata & mask) !== exp && n < 300) begin
      n++;
      apb_xfer(1'b0, STATUS_OFFSET, 32'h0);
    end
    check(rdata & mask, exp);
    if (n == 300) finish_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_xfer(1'b0, STATUS_OFFSET, 32'h0);
    check(rdata & MSK_ALL, st(4'h0, 1'b0, 1'b1));
    apb_xfer(1'b0, HALF_PERIOD_OFFSET, 32'h0);
    check(rdata, {16'h0000, HALF_PERIOD_RESET});
    apb_xfer(1'b0, 8'h10, 32'h0);
    check({31'h0, rerr}, 32'h1);
    check(rdata, 32'h0);
    // Long clock halves make the ripple pulse visible through STATUS.
    apb_xfer(1'b1, HALF_PERIOD_OFFSET, 32'h13);
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b1, 1'b0, 1'b0, 4'hE));
    wait_status(MSK_ALL, st(4'hE, 1'b0, 1'b1));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b1, 1'b1, 1'b0, 4'hE));
    apb_xfer(1'b1, PULSES_OFFSET, 32'h2);
    wait_status(MSK_ALL | MSK_BUSY, st(4'hE, 1'b0, 1'b1));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b0, 1'b0, 4'hE));
    repeat (10) @(posedge pclk);
    wait_status(MSK_ALL, st(4'hE, 1'b0, 1'b1));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b1, 1'b0, 4'hE));
    apb_xfer(1'b1, PULSES_OFFSET, 32'h1);
    wait_status(MSK_ALL, st(4'hF, 1'b1, 1'b0));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b0, 1'b0, 4'hF));
    wait_status(MSK_ALL, st(4'hF, 1'b1, 1'b1));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b1, 1'b0, 4'hF));
    apb_xfer(1'b1, PULSES_OFFSET, 32'h1);
    wait_status(MSK_ALL | MSK_BUSY, st(4'h0, 1'b0, 1'b1));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b1, 1'b1, 4'h0));
    wait_status(MSK_CF, st(4'h0, 1'b1, 1'b0));
    apb_xfer(1'b1, PULSES_OFFSET, 32'h1);
    wait_status(MSK_CF | MSK_BUSY, st(4'hF, 1'b0, 1'b0));
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b0, 1'b1, 4'h0));
    apb_xfer(1'b1, PULSES_OFFSET, 32'h3);
    wait_status(MSK_BUSY, 32'h0);
    repeat (6) @(posedge pclk);
    wait_status(MSK_CF, st(4'hF, 1'b0, 1'b0));
    check({27'h0, terminal_now, count_value}, {27'h0, 1'b0, 4'hF});
    // A free-running clock with counting inhibited must leave the count alone.
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b0, 1'b1, 4'h0) | MSK_RUN);
    wait_status(MSK_BUSY, MSK_BUSY);
    repeat (100) @(posedge pclk);
    apb_xfer(1'b1, CTRL_OFFSET, ctrl(1'b0, 1'b0, 1'b1, 4'h0));
    wait_status(MSK_ALL | MSK_BUSY, st(4'hF, 1'b0, 1'b1));
    finish_test();
  end
endmodule
`default_nettype wire
